//--- rtl/hlpc_map.vh
`ifndef HLPC_MAP_VH
`define HLPC_MAP_VH

// Bus nibble codes
`define HLPC_HUB_WRITE_START 4'he
`define HLPC_LPC_START 4'h0
`define HLPC_LPC_READ_TYPE 4'h4
`define HLPC_TURNAROUND 4'hf
`define HLPC_SYNC_READY 4'h0
`define HLPC_SYNC_WAIT 4'h5

// Transfer size codes
`define HLPC_SIZE_1BYTE 4'h0
`define HLPC_SIZE_2BYTE 4'h1
`define HLPC_SIZE_4BYTE 4'h2

// Nibbles sent before the turnaround, data excluded
`define HLPC_HUB_HEAD_NIBBLES 5'h0a
`define HLPC_LPC_NIBBLES 5'h0a

// Data nibbles per size
`define HLPC_DATA_NIB_1 5'h02
`define HLPC_DATA_NIB_2 5'h04
`define HLPC_DATA_NIB_4 5'h08

// Upper LPC address bits forced to one
`define HLPC_LPC_ADDR_TOP 9'h1ff
`define HLPC_LPC_ADDR_LO_W 23
`define HLPC_HUB_ADDR_W 28

// Frame held low to abort a cycle
`define HLPC_ABORT_CLKS 3'h4

// Wait-sync clocks that an in-spec single-byte read always shows
`define HLPC_READ_WAITS 8'h02

// Command kinds
`define HLPC_KIND_HUB_WRITE 1'b0
`define HLPC_KIND_LPC_READ 1'b1

`endif

//--- rtl/hlpc_buf.v
`timescale 1ns/10ps
`default_nettype none

// Shifting buffer: head entry and flags are flops so outputs are registered
module hlpc_buf #(
   parameter W = 10,
   parameter DEPTH = 2
) (
   input wire i_clk,
   input wire i_nrst,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [W-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [W-1:0] o_out_data,
   output wire [$clog2(DEPTH+1)-1:0] o_count
);

localparam CW = $clog2(DEPTH + 1);

reg [W-1:0] mem_r [0:DEPTH-1];
reg [DEPTH-1:0] vld_r;
reg [CW-1:0] cnt_r;
wire pop;
wire push;
wire [CW-1:0] wpos;

assign pop = vld_r[0] & i_out_ready;
assign push = i_in_valid & ~vld_r[DEPTH-1];
assign wpos = cnt_r - {{(CW-1){1'b0}}, pop};
assign o_in_ready = ~vld_r[DEPTH-1];
assign o_out_valid = vld_r[0];
assign o_out_data = mem_r[0];
assign o_count = cnt_r;

genvar i;
generate
   for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      localparam [CW-1:0] IDX = i;
      wire wsel;
      wire up_v;
      wire [W-1:0] up_d;
      assign wsel = push && (wpos == IDX);
      if (i < DEPTH - 1) begin : g_mid
         assign up_v = vld_r[i+1];
         assign up_d = mem_r[i+1];
      end else begin : g_last
         assign up_v = 1'b0;
         assign up_d = mem_r[i];
      end
      always @(posedge i_clk) begin
         if (!i_nrst) begin
            vld_r[i] <= 1'b0;
            mem_r[i] <= {W{1'b0}};
         end else begin
            if (wsel) begin
               mem_r[i] <= i_in_data;
            end else if (pop) begin
               mem_r[i] <= up_d;
            end
            vld_r[i] <= wsel | (pop ? up_v : vld_r[i]);
         end
      end
   end
endgenerate

always @(posedge i_clk) begin
   if (!i_nrst) begin
      cnt_r <= {CW{1'b0}};
   end else begin
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
   end
end

endmodule

`default_nettype wire

//--- rtl/hlpc_host.v
//Contract
//(RULE_01) Hub write starts with nibble 1110 while frame line is low.
//(RULE_02) Second hub write clock carries the one-nibble chip identifier.
//(RULE_03) Hub address: 28 bits over seven clocks, MSB nibble first.
//(RULE_04) Device ignores some hub address bits for array accesses.
//(RULE_05) Size nibble after address: 0000 one, 0001 two, 0010 four bytes.
//(RULE_06) Write data two clocks per byte, low nibble first.
//(RULE_07) Successive data bytes map to ascending low address bits.
//(RULE_08) Host drives 1111 one clock after the last data nibble.
//(RULE_09) Host releases data lines next clock; device takes over.
//(RULE_10) Device drives 0000 one clock to acknowledge the write.
//(RULE_11) Device then drives 1111, then floats the lines.
//(RULE_12) LPC cycle starts with 0000 while frame line is low.
//(RULE_13) LPC read cycle type nibble is 0100.
//(RULE_14) LPC address: 32 bits, eight clocks, MSB first, A23-A31 ones.
//(RULE_15) Device routes by address bit 22: array or registers.
//(RULE_16) Host drives 1111 after address, releases; device takes over.
//(RULE_17) Device gives exactly two wait-sync clocks of 0101.
//(RULE_18) Device then drives ready-sync 0000, data follows next clock.
//(RULE_19) Read byte returns in clocks 16 and 17, low nibble first.
//(RULE_20) Device drives 1111 in clock 18, floats in clock 19.
//(RULE_21) Unmatched chip identifier: device stays silent, no write.
`include "hlpc_map.vh"
`timescale 1ns/10ps
`default_nettype none

module hlpc_host #(
   parameter SYNC_LIMIT = 8,
   parameter BUF_DEPTH = 2
) (
   input wire i_clk,
   input wire i_nrst,
   input wire i_cmd_valid,
   output wire o_cmd_ready,
   input wire i_cmd_kind,
   input wire [31:0] i_cmd_addr,
   input wire [3:0] i_cmd_chip_id,
   input wire [1:0] i_cmd_size,
   input wire [31:0] i_cmd_data,
   output wire o_rsp_valid,
   input wire i_rsp_ready,
   output wire [7:0] o_rsp_data,
   output wire o_rsp_err,
   output wire o_rsp_kind,
   output wire [3:0] o_hub_nibble_lines_out,
   output wire o_hub_nibble_lines_oe_n,
   input wire [3:0] i_hub_nibble_lines_in,
   output wire o_hub_frame_line_n
);

localparam S_IDLE = 4'h0;
localparam S_TX = 4'h1;
localparam S_TAR = 4'h2;
localparam S_RX_TAR = 4'h3;
localparam S_SYNC = 4'h4;
localparam S_D0 = 4'h5;
localparam S_D1 = 4'h6;
localparam S_DTAR = 4'h7;
localparam S_FLOAT = 4'h8;
localparam S_ABORT = 4'h9;
localparam CW = $clog2(BUF_DEPTH + 1);
localparam [CW-1:0] BUF_FULL = BUF_DEPTH;
localparam [7:0] SYNC_MAX = SYNC_LIMIT;

reg [3:0] state_r;
reg [79:0] tx_sh_r;
reg [4:0] tx_left_r;
reg kind_r;
reg [7:0] wait_cnt_r;
reg [2:0] abort_cnt_r;
reg [7:0] rd_data_r;
reg push_r;
reg err_r;
reg ready_r;
reg [3:0] lad_r;
reg lad_oe_n_r;
reg frame_n_r;
reg [3:0] size_code;
reg [31:0] data_nib;
reg [4:0] data_cnt;
reg ready_nxt;

wire accept;
wire [CW-1:0] buf_count;
wire buf_pop;
wire [CW-1:0] cnt_after;
wire [79:0] hub_load;
wire [79:0] lpc_load;

assign accept = i_cmd_valid & ready_r;
assign buf_pop = o_rsp_valid & i_rsp_ready;
assign cnt_after = buf_count + {{(CW-1){1'b0}}, push_r}
   - {{(CW-1){1'b0}}, buf_pop};

//--------------------------------------------------
// Frame images
//--------------------------------------------------
always @* begin
   // Bytes go out in ascending order, each low nibble first
   data_nib = {i_cmd_data[3:0], i_cmd_data[7:4], // RULE_06 RULE_07
      i_cmd_data[11:8], i_cmd_data[15:12],
      i_cmd_data[19:16], i_cmd_data[23:20],
      i_cmd_data[27:24], i_cmd_data[31:28]};
   case (i_cmd_size)
      2'h0: begin
         size_code = `HLPC_SIZE_1BYTE; // RULE_05
         data_cnt = `HLPC_DATA_NIB_1;
      end
      2'h1: begin
         size_code = `HLPC_SIZE_2BYTE; // RULE_05
         data_cnt = `HLPC_DATA_NIB_2;
      end
      default: begin
         // Unsupported code 3 is sent as a four-byte write
         size_code = `HLPC_SIZE_4BYTE; // RULE_05
         data_cnt = `HLPC_DATA_NIB_4;
      end
   endcase
end

// Start, id, address MSB first, size, data
assign hub_load = {`HLPC_HUB_WRITE_START, i_cmd_chip_id, // RULE_01 RULE_02
   i_cmd_addr[`HLPC_HUB_ADDR_W-1:0], size_code, data_nib, // RULE_03
   8'h00};
// Bit 22 passes through so the caller picks array or registers
assign lpc_load = {`HLPC_LPC_START, `HLPC_LPC_READ_TYPE, // RULE_12 RULE_13
   `HLPC_LPC_ADDR_TOP, i_cmd_addr[`HLPC_LPC_ADDR_LO_W-1:0], // RULE_14 RULE_15
   40'h0000000000};

//--------------------------------------------------
// Ready: only when the buffer is sure to take the answer
//--------------------------------------------------
always @* begin
   ready_nxt = 1'b0;
   if (state_r == S_IDLE && !accept && cnt_after != BUF_FULL) begin
      ready_nxt = 1'b1;
   end
end

//--------------------------------------------------
// Cycle sequencer
//--------------------------------------------------
always @(posedge i_clk) begin
   if (!i_nrst) begin
      state_r <= S_IDLE;
      tx_sh_r <= 80'h0;
      tx_left_r <= 5'h00;
      kind_r <= 1'b0;
      wait_cnt_r <= 8'h00;
      abort_cnt_r <= 3'h0;
      rd_data_r <= 8'h00;
      push_r <= 1'b0;
      err_r <= 1'b0;
      ready_r <= 1'b0;
      lad_r <= `HLPC_TURNAROUND;
      lad_oe_n_r <= 1'b1;
      frame_n_r <= 1'b1;
   end else begin
      push_r <= 1'b0;
      ready_r <= ready_nxt;
      case (state_r)
         S_IDLE: begin
            if (accept) begin
               kind_r <= i_cmd_kind;
               err_r <= 1'b0;
               rd_data_r <= 8'h00;
               lad_oe_n_r <= 1'b0;
               frame_n_r <= 1'b0; // RULE_01 RULE_12
               state_r <= S_TX;
               if (i_cmd_kind == `HLPC_KIND_LPC_READ) begin
                  lad_r <= lpc_load[79:76];
                  tx_sh_r <= {lpc_load[75:0], 4'h0};
                  tx_left_r <= `HLPC_LPC_NIBBLES - 5'h01;
               end else begin
                  lad_r <= hub_load[79:76];
                  tx_sh_r <= {hub_load[75:0], 4'h0};
                  tx_left_r <= `HLPC_HUB_HEAD_NIBBLES + data_cnt - 5'h01;
               end
            end
         end
         S_TX: begin
            frame_n_r <= 1'b1;
            if (tx_left_r != 5'h00) begin
               lad_r <= tx_sh_r[79:76]; // RULE_03 RULE_06 RULE_14
               tx_sh_r <= {tx_sh_r[75:0], 4'h0};
               tx_left_r <= tx_left_r - 5'h01;
            end else begin
               lad_r <= `HLPC_TURNAROUND; // RULE_08 RULE_16
               state_r <= S_TAR;
            end
         end
         S_TAR: begin
            lad_oe_n_r <= 1'b1; // RULE_09 RULE_16
            state_r <= S_RX_TAR;
         end
         S_RX_TAR: begin
            wait_cnt_r <= 8'h00;
            state_r <= S_SYNC;
         end
         S_SYNC: begin
            if (i_hub_nibble_lines_in == `HLPC_SYNC_READY) begin
               // A read that saw other than two waits is flagged
               if (kind_r == `HLPC_KIND_LPC_READ) begin
                  err_r <= (wait_cnt_r != `HLPC_READ_WAITS); // RULE_17 RULE_18
                  state_r <= S_D0;
               end else begin
                  state_r <= S_DTAR; // RULE_10
               end
            end else if (wait_cnt_r == SYNC_MAX) begin
               // Silent target, e.g. no chip with this id
               err_r <= 1'b1; // RULE_21
               lad_r <= `HLPC_TURNAROUND;
               lad_oe_n_r <= 1'b0;
               frame_n_r <= 1'b0;
               abort_cnt_r <= `HLPC_ABORT_CLKS - 3'h1;
               state_r <= S_ABORT;
            end else begin
               wait_cnt_r <= wait_cnt_r + 8'h01; // RULE_17
            end
         end
         S_D0: begin
            rd_data_r[3:0] <= i_hub_nibble_lines_in; // RULE_19
            state_r <= S_D1;
         end
         S_D1: begin
            rd_data_r[7:4] <= i_hub_nibble_lines_in; // RULE_19
            state_r <= S_DTAR;
         end
         S_DTAR: begin
            // Device drives 1111 here; value is not checked
            state_r <= S_FLOAT; // RULE_11 RULE_20
         end
         S_FLOAT: begin
            push_r <= 1'b1; // RULE_11 RULE_20
            state_r <= S_IDLE;
         end
         S_ABORT: begin
            if (abort_cnt_r != 3'h0) begin
               abort_cnt_r <= abort_cnt_r - 3'h1;
            end else begin
               frame_n_r <= 1'b1;
               lad_oe_n_r <= 1'b1;
               push_r <= 1'b1;
               state_r <= S_IDLE;
            end
         end
         default: begin
            state_r <= S_IDLE;
         end
      endcase
   end
end

//--------------------------------------------------
// Answer buffer
//--------------------------------------------------
// Commands are held off while the buffer could fill, so no answer drops
hlpc_buf #(
   .W(10),
   .DEPTH(BUF_DEPTH)
) u_buf (
   .i_clk(i_clk),
   .i_nrst(i_nrst),
   .i_in_valid(push_r),
   .o_in_ready(),
   .i_in_data({kind_r, err_r, rd_data_r}),
   .o_out_valid(o_rsp_valid),
   .i_out_ready(i_rsp_ready),
   .o_out_data({o_rsp_kind, o_rsp_err, o_rsp_data}),
   .o_count(buf_count)
);

// ready_r is only set when the buffer has room, so the port is a bare flop
assign o_cmd_ready = ready_r;
assign o_hub_nibble_lines_out = lad_r;
assign o_hub_nibble_lines_oe_n = lad_oe_n_r;
assign o_hub_frame_line_n = frame_n_r;

endmodule

`default_nettype wire

//--- verification/hlpc_host_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module hlpc_host_monitor #(
   parameter SYNC_LIMIT = 8,
   parameter BUF_DEPTH = 2
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_valid,
   input wire logic o_cmd_ready,
   input wire logic i_cmd_kind,
   input wire logic [31:0] i_cmd_addr,
   input wire logic [3:0] i_cmd_chip_id,
   input wire logic [1:0] i_cmd_size,
   input wire logic o_rsp_valid,
   input wire logic o_rsp_kind,
   input wire logic [3:0] o_hub_nibble_lines_out,
   input wire logic o_hub_nibble_lines_oe_n,
   input wire logic o_hub_frame_line_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire take = i_cmd_valid && o_cmd_ready;
   wire [3:0] nib = o_hub_nibble_lines_out;
   wire oe_n = o_hub_nibble_lines_oe_n;
   wire [3:0] top_nib = i_cmd_addr[27:24];
   // Size 3 goes out as the four-byte code
   wire [3:0] sz_code = i_cmd_size == 2'h3 ? 4'h2 : {2'h0, i_cmd_size};
   sequence s_lpc; take && i_cmd_kind; endsequence
   sequence s_hub; take && !i_cmd_kind; endsequence
   sequence s_host_tar; nib == 4'hf && !oe_n ##1 oe_n; endsequence
   chk_start_code: assert property (
      take |=> !o_hub_frame_line_n && !oe_n &&
      nib == ($past(i_cmd_kind) ? 4'h0 : 4'he)) else $error("bad start");
   chk_lpc_type: assert property (
      s_lpc |-> ##2 o_hub_frame_line_n && nib == 4'h4)
      else $error("bad cycle type");
   chk_lpc_top: assert property (
      s_lpc |-> ##3 nib == 4'hf ##1 nib == 4'hf ##1 nib[3])
      else $error("bad upper address");
   chk_lpc_tar: assert property (
      s_lpc |-> ##11 s_host_tar) else $error("bad read turnaround");
   chk_hub_id: assert property (
      s_hub |-> ##2 nib == $past(i_cmd_chip_id, 2) ##1
      nib == $past(top_nib, 3)) else $error("bad id or address");
   chk_hub_size: assert property (
      s_hub |-> ##10 nib == $past(sz_code, 10)) else $error("bad size");
   chk_hub_tar: assert property (
      (s_hub and (i_cmd_size == 2'h0)) |-> ##13 s_host_tar)
      else $error("bad write turnaround");
   chk_rd_answer: assert property (
      s_lpc |-> ##[19:23] o_rsp_valid && o_rsp_kind)
      else $error("read answer late");
endmodule
bind hlpc_host hlpc_host_monitor #(
   .SYNC_LIMIT(SYNC_LIMIT), .BUF_DEPTH(BUF_DEPTH)
) hlpc_host_monitor_i (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
   .o_cmd_ready(o_cmd_ready), .i_cmd_kind(i_cmd_kind),
   .i_cmd_addr(i_cmd_addr), .i_cmd_chip_id(i_cmd_chip_id),
   .i_cmd_size(i_cmd_size), .o_rsp_valid(o_rsp_valid),
   .o_rsp_kind(o_rsp_kind), .o_hub_nibble_lines_out(o_hub_nibble_lines_out),
   .o_hub_nibble_lines_oe_n(o_hub_nibble_lines_oe_n),
   .o_hub_frame_line_n(o_hub_frame_line_n)
);
`default_nettype wire

//--- verification/hlpc_dev.sv
`timescale 1ns/10ps
`default_nettype none
module hlpc_dev (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_frame_n,
   input wire logic [3:0] i_bus,
   input wire logic [3:0] i_id,
   input wire logic [2:0] i_waits,
   output logic [3:0] o_out,
   output logic o_oe_n,
   output logic [27:0] o_wr_addr,
   output logic [31:0] o_wr_data,
   output logic [7:0] o_wr_n,
   output logic [31:0] o_rd_addr
);
   logic [5:0] n_r, m_r;
   logic lpc_r, hit_r;
   logic [31:0] a_r, d_r;
   // c is the bus clock being sampled or driven next
   wire [5:0] c = n_r + 6'h01;
   wire [5:0] w = 6'h0c + {3'h0, i_waits};
   wire [7:0] rd = a_r[22] ? a_r[7:0] ^ 8'h5a : 8'h3c;
   always_comb begin
      o_oe_n = 1'b1;
      o_out = 4'hf;
      if (lpc_r && c > 6'h0c && c < w + 6'h05) begin
         o_oe_n = 1'b0;
         o_out = c <= w ? 4'h5 : c == w + 6'h01 ? 4'h0 :
            c == w + 6'h02 ? rd[3:0] :
            c == w + 6'h03 ? rd[7:4] : 4'hf;
      end
      if (!lpc_r && hit_r &&
          c > m_r + 6'h0c && c < m_r + 6'h0f) begin
         o_oe_n = 1'b0;
         o_out = c == m_r + 6'h0d ? 4'h0 : 4'hf;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         n_r <= 6'h00;
         lpc_r <= 1'b0;
         hit_r <= 1'b0;
         o_wr_n <= 8'h00;
      end else if (n_r == 6'h00) begin
         if (!i_frame_n &&
             (i_bus == 4'he || i_bus == 4'h0)) begin
            n_r <= 6'h01;
            lpc_r <= i_bus == 4'h0;
            d_r <= 32'h0;
            m_r <= 6'h20;
         end
      end else begin
         n_r <= n_r == (lpc_r ? w + 6'h04 : m_r + 6'h0e) ? 6'h00 : c;
         if (c == 6'h02)
            hit_r <= lpc_r || i_bus == i_id;
         if (c > 6'h02 && c < (lpc_r ? 6'h0b : 6'h0a))
            a_r <= {a_r[27:0], i_bus};
         if (!lpc_r && c == 6'h0a)
            m_r <= i_bus == 4'h0 ? 6'h02 :
               i_bus == 4'h1 ? 6'h04 : 6'h08;
         if (!lpc_r && c > 6'h0a && c < m_r + 6'h0b)
            d_r[4 * (c - 6'h0b) +: 4] <= i_bus;
         if (lpc_r && c == 6'h0b)
            o_rd_addr <= a_r;
         if (!lpc_r && hit_r && c == m_r + 6'h0d) begin
            // Array access: only bits 22 and 19..0 count
            o_wr_addr <= a_r[22] ? a_r[27:0] & 28'h04fffff :
               a_r[27:0];
            o_wr_data <= d_r;
            o_wr_n <= o_wr_n + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/hlpc_host_test.sv
`timescale 1ns/10ps
`default_nettype none
module hlpc_host_test;
   logic i_clk = 1'b0, i_nrst = 1'b0, cv = 1'b0, ck = 1'b0, rr = 1'b0;
   logic [31:0] ca = 32'h0, cd = 32'h0;
   logic [3:0] cid = 4'h0;
   logic [1:0] cs = 2'h0;
   logic [2:0] waits = 3'h2;
   wire rdy, rv, re, rk, oe_n, fr_n, d_oe_n;
   wire [7:0] rdat, wr_n;
   wire [3:0] hout, dout;
   wire [27:0] wr_addr;
   wire [31:0] wr_data, rd_addr;
   // Pull-ups hold released lines at all ones
   wire [3:0] bus = !oe_n ? hout : !d_oe_n ? dout : 4'hf;
   int n_fail = 0, n_checks = 0;
   hlpc_host #(.SYNC_LIMIT(3), .BUF_DEPTH(2)) hlpc_host_i (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(cv), .o_cmd_ready(rdy),
      .i_cmd_kind(ck), .i_cmd_addr(ca), .i_cmd_chip_id(cid), .i_cmd_size(cs),
      .i_cmd_data(cd), .o_rsp_valid(rv), .i_rsp_ready(rr), .o_rsp_data(rdat),
      .o_rsp_err(re), .o_rsp_kind(rk), .o_hub_nibble_lines_out(hout),
      .o_hub_nibble_lines_oe_n(oe_n), .i_hub_nibble_lines_in(bus),
      .o_hub_frame_line_n(fr_n));
   hlpc_dev hlpc_dev_i (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_frame_n(fr_n), .i_bus(bus),
      .i_id(4'h3), .i_waits(waits), .o_out(dout), .o_oe_n(d_oe_n),
      .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_wr_n(wr_n),
      .o_rd_addr(rd_addr));
   initial forever #5 i_clk = ~i_clk;
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task send(input logic k, input logic [31:0] a, input logic [3:0] id,
             input logic [1:0] sz, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cv <= 1'b1;
      {ck, ca, cid, cs, cd} <= {k, a, id, sz, d};
      do begin
         @(posedge i_clk);
         n++;
      end while (rdy !== 1'b1 && n < 100);
      if (rdy !== 1'b1) n_fail++;
      cv <= 1'b0;
   endtask
   task recv(output logic [9:0] r);
      int n;
      n = 0;
      rr <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (rv !== 1'b1 && n < 100);
      if (rv !== 1'b1) n_fail++;
      r = {rdat, re, rk};
      rr <= 1'b0;
      // One edge with ready low keeps back-to-back calls from toggling rr
      @(posedge i_clk);
   endtask
   task t_hub;
      logic [31:0] a, d, ea, ed;
      logic [9:0] r;
      for (int i = 0; i < 4; i++) begin
         a = i == 0 ? 32'h0a312345 : 32'h0f7a5a24 + (i << 12);
         d = 32'h8c4b1e97 ^ (i * 32'h01010101);
         send(1'b0, a, 4'h3, i[1:0], d);
         recv(r);
         chk(r[1:0], 2'b00);
         chk(wr_n, i + 1);
         ea = a[22] ? a[27:0] & 28'h04fffff : a[27:0];
         chk(wr_addr, ea);
         ed = i == 0 ? d & 32'hff : i == 1 ? d & 32'hffff : d;
         chk(wr_data, ed);
      end
      $display("hub write test done");
   endtask
   task t_lpc;
      logic [31:0] a;
      logic [9:0] r;
      logic [9:0] e;
      for (int i = 0; i < 3; i++) begin
         a = i == 1 ? 32'h00001234 : 32'h00403a5c + i;
         waits <= i == 2 ? 3'h3 : 3'h2;
         send(1'b1, a, 4'h0, 2'h0, 32'h0);
         recv(r);
         e = {a[22] ? a[7:0] ^ 8'h5a : 8'h3c, i == 2, 1'b1};
         chk(r, e);
         chk(rd_addr, {9'h1ff, a[22:0]});
      end
      waits <= 3'h2;
      $display("lpc read test done");
   endtask
   task t_bad_id;
      logic [9:0] r;
      send(1'b0, 32'h0f400000, 4'h9, 2'h0, 32'h55);
      recv(r);
      chk(r[1:0], 2'b10);
      chk(wr_n, 8'h04);
      $display("wrong id test done");
   endtask
   task t_buffer;
      logic [9:0] r;
      send(1'b1, 32'h00400011, 4'h0, 2'h0, 32'h0);
      send(1'b1, 32'h00400022, 4'h0, 2'h0, 32'h0);
      repeat (30) @(posedge i_clk);
      chk(rdy, 1'b0);
      recv(r);
      chk(r, {8'h4b, 2'b01});
      recv(r);
      chk(r, {8'h78, 2'b01});
      $display("buffer test done");
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      chk({fr_n, oe_n, hout, rdy, rv}, 8'hfc);
      i_nrst <= 1'b1;
      t_hub;
      t_lpc;
      t_bad_id;
      t_buffer;
      give_verdict;
   end
   initial begin
      #50000;
      n_fail++;
      give_verdict;
   end
endmodule
`default_nettype wire
